/* rtl/acp_clock_synth_regs.sv */
// adc clock synthesizer register bank with serial access and lsb dither generator
`timescale 1ns/10ps
module acp_clock_synth_regs #(
    parameter int REG_W = 26
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // serial control port
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    output logic o_dout,
    // synthesizer controls
    output logic [19:0] o_synth_fraction_ratio,
    output logic [7:0] o_synth_integer_ratio,
    output logic o_ref_divider_select,
    output logic [2:0] o_pump_current_code,
    output logic o_rational_div_enable,
    output logic o_frac_mode_select,
    output logic [7:0] o_dither_high_count,
    output logic [7:0] o_dither_low_count,
    output logic o_recovery_halving_enable,
    // fractional lsb dither
    output logic o_dither_lsb
);
    logic fall, hdr_done, frame_done;
    logic [31:0] word;
    logic [REG_W-1:0] frac_reg, syn_reg, misc_reg, spare_reg;
    logic [REG_W-1:0] next_frac, next_syn, next_misc, next_spare;
    logic [REG_W-1:0] rd_shift, next_rd_shift;
    logic rd_pending, next_rd_pending, rd_active, next_rd_active, next_dout;
    logic [4:0] rd_addr, next_rd_addr;
    acp_pkg::acp_dith_state_t dstate, next_dstate;
    logic [7:0] dcnt, next_dcnt;
    logic next_dither;

    // 3'h0..3 for mapped registers, bit 2 set for unmapped
    function automatic logic [2:0] reg_index(input logic [4:0] addr);
        if (addr == acp_pkg::ADDR_FRAC) begin
            reg_index = 3'h0;
        end else if (addr == acp_pkg::ADDR_SYN) begin
            reg_index = 3'h1;
        end else if (addr == acp_pkg::ADDR_MISC) begin
            reg_index = 3'h2;
        end else if (addr == acp_pkg::ADDR_SPARE) begin
            reg_index = 3'h3;
        end else begin
            reg_index = 3'h4;
        end
    endfunction : reg_index

    acp_serial_shifter u_shift (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_cs_n(i_cs_n),
        .i_sclk(i_sclk),
        .i_din(i_din),
        .o_fall(fall),
        .o_hdr_done(hdr_done),
        .o_frame_done(frame_done),
        .o_word(word)
    );

    // register writes at the end of a complete write frame
    always_comb begin
        logic [2:0] idx;
        logic [REG_W-1:0] data;
        idx = reg_index(word[acp_pkg::FR_ADDR_LSB +: acp_pkg::ADDR_W]);
        data = word[REG_W-1:0];
        next_frac = frac_reg;
        next_syn = syn_reg;
        next_misc = misc_reg;
        next_spare = spare_reg;
        if (frame_done && !word[acp_pkg::FR_RD_BIT]) begin
            if (idx == 3'h0) begin
                next_frac = data;
            end else if (idx == 3'h1) begin
                next_syn = data;
            end else if (idx == 3'h2) begin
                next_misc = data;
            end else if (idx == 3'h3) begin
                next_spare = data;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            frac_reg <= acp_pkg::RST_FRAC;
            syn_reg <= acp_pkg::RST_SYN;
            misc_reg <= acp_pkg::RST_MISC;
            spare_reg <= acp_pkg::RST_SPARE;
        end else begin
            frac_reg <= next_frac;
            syn_reg <= next_syn;
            misc_reg <= next_misc;
            spare_reg <= next_spare;
        end
    end

    // field outputs taken straight from the register flops
    assign o_synth_fraction_ratio = frac_reg[acp_pkg::FRAC_LSB +: acp_pkg::FRAC_W];
    assign o_synth_integer_ratio = syn_reg[acp_pkg::INT_LSB +: acp_pkg::INT_W];
    assign o_ref_divider_select = syn_reg[acp_pkg::REFDIV_BIT];
    assign o_pump_current_code = syn_reg[acp_pkg::PUMP_LSB +: acp_pkg::PUMP_W];
    assign o_rational_div_enable = syn_reg[acp_pkg::RATDIV_BIT];
    assign o_frac_mode_select = syn_reg[acp_pkg::FRACMODE_BIT];
    assign o_dither_high_count = misc_reg[acp_pkg::DHI_LSB +: acp_pkg::DCNT_W];
    assign o_dither_low_count = misc_reg[acp_pkg::DLO_LSB +: acp_pkg::DCNT_W];
    assign o_recovery_halving_enable = misc_reg[acp_pkg::HALVE_BIT];

    // read path: header latched, data driven msb first on sclk falling edges
    always_comb begin
        logic [2:0] ridx;
        logic [REG_W-1:0] rdata;
        ridx = reg_index(rd_addr);
        rdata = '0;
        if (ridx == 3'h0) begin
            rdata = frac_reg;
        end else if (ridx == 3'h1) begin
            rdata = syn_reg;
        end else if (ridx == 3'h2) begin
            rdata = misc_reg;
        end else if (ridx == 3'h3) begin
            rdata = spare_reg;
        end
        next_rd_addr = rd_addr;
        next_rd_pending = rd_pending;
        next_rd_active = rd_active;
        next_rd_shift = rd_shift;
        next_dout = o_dout;
        if (i_cs_n) begin
            next_rd_pending = 1'b0;
            next_rd_active = 1'b0;
            next_dout = 1'b0;
        end else if (hdr_done) begin
            next_rd_addr = word[acp_pkg::ADDR_W-1:0];
            next_rd_pending = word[acp_pkg::HDR_RD_BIT];
        end else if (fall && rd_pending) begin
            next_rd_pending = 1'b0;
            next_rd_active = 1'b1;
            next_dout = rdata[REG_W-1];
            next_rd_shift = {rdata[REG_W-2:0], 1'b0};
        end else if (fall && rd_active) begin
            next_dout = rd_shift[REG_W-1];
            next_rd_shift = {rd_shift[REG_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rd_addr <= 5'h00;
            rd_pending <= 1'b0;
            rd_active <= 1'b0;
            rd_shift <= '0;
            o_dout <= 1'b0;
        end else begin
            rd_addr <= next_rd_addr;
            rd_pending <= next_rd_pending;
            rd_active <= next_rd_active;
            rd_shift <= next_rd_shift;
            o_dout <= next_dout;
        end
    end

    // lsb dither: high for the high count, low for the low count, in fractional mode
    always_comb begin
        logic [7:0] hi;
        logic [7:0] lo;
        hi = o_dither_high_count;
        lo = o_dither_low_count;
        next_dstate = dstate;
        next_dcnt = dcnt;
        if (!o_frac_mode_select || (hi == 8'h00 && lo == 8'h00)) begin
            next_dstate = acp_pkg::DITH_IDLE;
            next_dcnt = 8'h00;
        end else begin
            case (dstate)
                acp_pkg::DITH_HIGH: begin
                    if (dcnt != 8'h00) begin
                        next_dcnt = dcnt - 8'h01;
                    end else if (lo != 8'h00) begin
                        next_dstate = acp_pkg::DITH_LOW;
                        next_dcnt = lo - 8'h01;
                    end else begin
                        next_dcnt = hi - 8'h01;
                    end
                end
                acp_pkg::DITH_LOW: begin
                    if (dcnt != 8'h00) begin
                        next_dcnt = dcnt - 8'h01;
                    end else if (hi != 8'h00) begin
                        next_dstate = acp_pkg::DITH_HIGH;
                        next_dcnt = hi - 8'h01;
                    end else begin
                        next_dcnt = lo - 8'h01;
                    end
                end
                default: begin
                    if (hi != 8'h00) begin
                        next_dstate = acp_pkg::DITH_HIGH;
                        next_dcnt = hi - 8'h01;
                    end else begin
                        next_dstate = acp_pkg::DITH_LOW;
                        next_dcnt = lo - 8'h01;
                    end
                end
            endcase
        end
        next_dither = (next_dstate == acp_pkg::DITH_HIGH);
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            dstate <= acp_pkg::DITH_IDLE;
            dcnt <= 8'h00;
            o_dither_lsb <= 1'b0;
        end else begin
            dstate <= next_dstate;
            dcnt <= next_dcnt;
            o_dither_lsb <= next_dither;
        end
    end

    // helper counters: run length of the dither level and quiet time since the last complete frame, read or write
    logic [8:0] run_len;
    logic [9:0] quiet;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            run_len <= 9'h000;
            quiet <= 10'h000;
        end else begin
            run_len <= (o_dither_lsb != next_dither) ? 9'h001 : run_len + 9'h001;
            quiet <= frame_done ? 10'h000 : ((quiet == 10'h3ff) ? quiet : quiet + 10'h001);
        end
    end

    // write effects on the decoded fields
    a_frac_field: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (frame_done && !word[31] && word[30:26] == 5'h0e)
        |=> o_synth_fraction_ratio == $past(word[19:0]))
        else $error("fractional ratio not taken from bits 19:0");
    a_int_field: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (frame_done && !word[31] && word[30:26] == 5'h0f)
        |=> o_synth_integer_ratio == $past(word[7:0]))
        else $error("integer ratio not taken from bits 7:0");
    a_ref_div: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (frame_done && !word[31] && word[30:26] == 5'h0f)
        |=> o_ref_divider_select == $past(word[8]))
        else $error("reference divide select not bit 8");
    a_pump_code: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (frame_done && !word[31] && word[30:26] == 5'h0f)
        |=> o_pump_current_code == $past(word[20:18]))
        else $error("pump code not bits 20:18");
    a_rational_mode: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (frame_done && !word[31] && word[30:26] == 5'h0f)
        |=> o_rational_div_enable == $past(word[22]) && o_frac_mode_select == $past(word[23]))
        else $error("rational enable or mode select misplaced");
    a_integer_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !o_frac_mode_select [*2] |-> !o_dither_lsb)
        else $error("dither active in integer mode");
    a_dither_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (quiet == 10'h3ff && o_dither_lsb && !next_dither && o_dither_low_count != 8'h00)
        |-> run_len == {1'b0, o_dither_high_count})
        else $error("dither high run length wrong");
    a_dither_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (quiet == 10'h3ff && !o_dither_lsb && next_dither && dstate == acp_pkg::DITH_LOW)
        |-> run_len == {1'b0, o_dither_low_count})
        else $error("dither low run length wrong");
    a_halving_bit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (frame_done && !word[31] && word[30:26] == 5'h10)
        |=> o_recovery_halving_enable == $past(word[20]))
        else $error("halving enable not bit 20");
    a_unmapped_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (frame_done && (word[30:26] < 5'h0e || word[30:26] > 5'h11))
        |=> $stable(frac_reg) && $stable(syn_reg) && $stable(misc_reg) && $stable(spare_reg))
        else $error("unmapped address changed a register");
    a_store_all: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (frame_done && !word[31] && word[30:26] == 5'h11)
        |=> spare_reg == $past(word[25:0]))
        else $error("spare register not stored whole");

    // registers move only at the end of a write frame, never on reads
    a_mid_frame_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !frame_done
        |=> $stable(frac_reg) && $stable(syn_reg) && $stable(misc_reg) && $stable(spare_reg))
        else $error("register changed outside a frame end");
    a_read_no_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (frame_done && word[31])
        |=> $stable(frac_reg) && $stable(syn_reg) && $stable(misc_reg) && $stable(spare_reg))
        else $error("read frame changed a register");

    // serial data line and dither stay quiet when they have nothing to show
    a_dout_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $past(i_cs_n) |-> !o_dout)
        else $error("read data driven while deselected");
    a_dither_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_dither_high_count == 8'h00 && o_dither_low_count == 8'h00) [*2] |-> !o_dither_lsb)
        else $error("dither active with both counts zero");
endmodule : acp_clock_synth_regs

/* rtl/acp_pkg.sv */
// constants for the adc clock synthesizer configuration registers
package acp_pkg;
    localparam int REG_W = 26;
    localparam int ADDR_W = 5;
    localparam int FRAME_BITS = 32;
    localparam int HDR_BITS = 6;
    localparam int CNT_W = 6;
    // register addresses
    localparam logic [4:0] ADDR_FRAC = 5'h0e;
    localparam logic [4:0] ADDR_SYN = 5'h0f;
    localparam logic [4:0] ADDR_MISC = 5'h10;
    localparam logic [4:0] ADDR_SPARE = 5'h11;
    // frame layout: read flag, address, data, msb first
    localparam int FR_RD_BIT = 31;
    localparam int FR_ADDR_LSB = 26;
    localparam int HDR_RD_BIT = 5;
    // field positions
    localparam int FRAC_LSB = 0;
    localparam int FRAC_W = 20;
    localparam int INT_LSB = 0;
    localparam int INT_W = 8;
    localparam int REFDIV_BIT = 8;
    localparam int PUMP_LSB = 18;
    localparam int PUMP_W = 3;
    localparam int RATDIV_BIT = 22;
    localparam int FRACMODE_BIT = 23;
    localparam int DHI_LSB = 0;
    localparam int DLO_LSB = 8;
    localparam int DCNT_W = 8;
    localparam int HALVE_BIT = 20;
    // reset values
    localparam logic [25:0] RST_FRAC = 26'h2100000;
    localparam logic [25:0] RST_SYN = 26'h2cc0c40;
    localparam logic [25:0] RST_MISC = 26'h00c0000;
    localparam logic [25:0] RST_SPARE = 26'h0000000;
    // dither generator states
    typedef enum logic [2:0] {
        DITH_IDLE = 3'b001,
        DITH_HIGH = 3'b010,
        DITH_LOW = 3'b100
    } acp_dith_state_t;
endpackage : acp_pkg

/* rtl/acp_serial_shifter.sv */
// serial control port front end: edge detect, shift in and frame count
`timescale 1ns/10ps
module acp_serial_shifter (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // serial pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    // events toward the register bank
    output logic o_fall,
    output logic o_hdr_done,
    output logic o_frame_done,
    output logic [31:0] o_word
);
    logic sclk_q, cs_n_q;
    logic [5:0] count;
    logic next_sclk_q, next_cs_n_q, next_fall, next_hdr_done, next_frame_done;
    logic [5:0] next_count;
    logic [31:0] next_word;

    // shift on sclk rising edges while selected, finish on deselect
    always_comb begin
        logic rise;
        rise = 1'b0;
        next_sclk_q = i_sclk;
        next_cs_n_q = i_cs_n;
        next_count = count;
        next_word = o_word;
        next_hdr_done = 1'b0;
        next_fall = !i_cs_n && !i_sclk && sclk_q;
        next_frame_done = i_cs_n && !cs_n_q && (count == 6'(acp_pkg::FRAME_BITS));
        rise = !i_cs_n && i_sclk && !sclk_q;
        if (i_cs_n) begin
            next_count = 6'h00;
        end else if (rise) begin
            next_word = {o_word[30:0], i_din};
            if (count != 6'h3f) begin
                next_count = count + 6'h01;
            end
            next_hdr_done = (count == 6'(acp_pkg::HDR_BITS - 1));
        end
    end

    // register the front end state
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            count <= 6'h00;
            o_word <= 32'h00000000;
            o_fall <= 1'b0;
            o_hdr_done <= 1'b0;
            o_frame_done <= 1'b0;
        end else begin
            sclk_q <= next_sclk_q;
            cs_n_q <= next_cs_n_q;
            count <= next_count;
            o_word <= next_word;
            o_fall <= next_fall;
            o_hdr_done <= next_hdr_done;
            o_frame_done <= next_frame_done;
        end
    end
endmodule : acp_serial_shifter

/* test/acp_host_model.sv */
// host controller model driving the serial control port of the register bank
`timescale 1ns/10ps
module acp_host_model (
    // clock
    input wire logic i_clk_sys,
    // serial pins
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din,
    input wire logic i_dout
);
    // idle bus: deselected, clock low
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
    end

    // one frame: read flag, address, data msb first; each sclk half is 3 clocks
    task automatic xfer(input logic rd, input logic [4:0] addr, input logic [25:0] data,
                        input int rises, output logic [25:0] rdata);
        logic [31:0] word;
        word = {rd, addr, data};
        rdata = 26'h0;
        @(negedge i_clk_sys);
        o_cs_n <= 1'b0;
        @(negedge i_clk_sys);
        for (int k = 1; k <= rises; k++) begin
            // read bits are settled by now, one half period after the fall
            if (rd && k >= 7 && k <= 32) begin
                rdata[32 - k] = i_dout;
            end
            o_din <= word[31 - ((k - 1) % 32)];
            o_sclk <= 1'b1;
            repeat (3) @(negedge i_clk_sys);
            o_sclk <= 1'b0;
            o_din <= ~o_din; // data is not held past the high phase
            repeat (3) @(negedge i_clk_sys);
        end
        o_cs_n <= 1'b1;
        o_din <= ~o_din;
        repeat (3) @(negedge i_clk_sys); // deselect time before the next frame
    endtask : xfer
endmodule : acp_host_model

/* test/adc_clock_pll_config_regs_tb.sv */
// self-checking bench for the adc clock synthesizer register bank
`timescale 1ns/10ps
`define CHK(a, b) \
    begin \
        compares++; \
        if ((a) !== (b)) begin \
            errors++; \
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); \
        end \
    end
module adc_clock_pll_config_regs_tb;
    // clock, reset and pins
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic cs_n, sclk, din, dout, dith, refdiv, ratdiv, fmode, halve;
    logic [19:0] frac;
    logic [7:0] intr, dhi, dlo;
    logic [2:0] pump;
    int errors = 0;
    int compares = 0;

    // 10 MHz clock
    always #50 i_clk_sys = ~i_clk_sys;

    acp_host_model i_host (.i_clk_sys(i_clk_sys), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_din(din), .i_dout(dout));
    acp_clock_synth_regs #(.REG_W(26)) i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .o_dout(dout),
        .o_synth_fraction_ratio(frac), .o_synth_integer_ratio(intr),
        .o_ref_divider_select(refdiv), .o_pump_current_code(pump),
        .o_rational_div_enable(ratdiv), .o_frac_mode_select(fmode),
        .o_dither_high_count(dhi), .o_dither_low_count(dlo),
        .o_recovery_halving_enable(halve), .o_dither_lsb(dith));

    // verdict and end of run
    task automatic close_out();
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // register write, then time for the fields to settle
    task automatic wr(input logic [4:0] a, input logic [25:0] d, input int rises = 32);
        logic [25:0] unused;
        i_host.xfer(1'b0, a, d, rises, unused);
        repeat (3) @(negedge i_clk_sys);
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [25:0] d);
        i_host.xfer(1'b1, a, 26'h3ffffff, 32, d);
    endtask : rd

    // every field output against the three register images
    task automatic chk_all(input logic [25:0] f, input logic [25:0] s, input logic [25:0] m);
        `CHK(frac, f[19:0])
        `CHK(intr, s[7:0])
        `CHK(refdiv, s[8])
        `CHK(pump, s[20:18])
        `CHK(ratdiv, s[22])
        `CHK(fmode, s[23])
        `CHK(dhi, m[7:0])
        `CHK(dlo, m[15:8])
        `CHK(halve, m[20])
    endtask : chk_all

    // reset values on the fields and through read back
    task automatic t_reset_values();
        logic [25:0] d;
        chk_all(acp_pkg::RST_FRAC, acp_pkg::RST_SYN, acp_pkg::RST_MISC);
        `CHK(dout, 1'b0)
        `CHK(dith, 1'b0)
        rd(acp_pkg::ADDR_SYN, d);
        `CHK(d, acp_pkg::RST_SYN)
        rd(acp_pkg::ADDR_SPARE, d);
        `CHK(d, acp_pkg::RST_SPARE)
    endtask : t_reset_values

    // host loads mode values with reserved defaults, all bits read back
    task automatic t_write_read();
        logic [4:0] adr [4];
        logic [25:0] val [4];
        logic [25:0] d;
        adr = '{acp_pkg::ADDR_FRAC, acp_pkg::ADDR_SYN, acp_pkg::ADDR_MISC, acp_pkg::ADDR_SPARE};
        val = '{26'h2185e85, 26'h2500d60, 26'h01c0e0b, 26'h2aaaaaa};
        for (int i = 0; i < 4; i++) begin
            wr(adr[i], val[i]);
        end
        chk_all(val[0], val[1], val[2]);
        for (int i = 0; i < 4; i++) begin
            rd(adr[i], d);
            `CHK(d, val[i])
        end
        wr(acp_pkg::ADDR_FRAC, 26'h2104000);
        `CHK(frac, 20'h04000)
    endtask : t_write_read

    // every legal pump code lands in the pump field
    task automatic t_pump_codes();
        logic [2:0] codes [5];
        codes = '{3'b001, 3'b010, 3'b011, 3'b100, 3'b111};
        for (int i = 0; i < 5; i++) begin
            wr(acp_pkg::ADDR_SYN, 26'h2c00c41 | (26'(codes[i]) << 18));
            `CHK(pump, codes[i])
            `CHK(intr, 8'h41)
        end
    endtask : t_pump_codes

    // unmapped addresses and miscounted frames leave everything alone
    task automatic t_refused();
        logic [25:0] d;
        wr(acp_pkg::ADDR_SYN, 26'h2500d60);
        wr(5'h0d, 26'h1555555);
        wr(5'h12, 26'h1555555);
        wr(acp_pkg::ADDR_FRAC, 26'h0012345, 31);
        wr(acp_pkg::ADDR_MISC, 26'h0000000, 33);
        chk_all(26'h2104000, 26'h2500d60, 26'h01c0e0b);
        rd(5'h12, d);
        `CHK(d, 26'h0)
    endtask : t_refused

    // dither high and low run lengths, then silence in integer mode
    task automatic t_dither();
        int n;
        wr(acp_pkg::ADDR_SYN, 26'h2d00d60);
        wr(acp_pkg::ADDR_MISC, 26'h00c0503);
        n = 0;
        while (dith !== 1'b0 && n < 50) begin
            n++;
            @(negedge i_clk_sys);
        end
        while (dith !== 1'b1 && n < 100) begin
            n++;
            @(negedge i_clk_sys);
        end
        n = 0;
        while (dith === 1'b1 && n < 300) begin
            n++;
            @(negedge i_clk_sys);
        end
        `CHK(n, 3)
        n = 0;
        while (dith === 1'b0 && n < 300) begin
            n++;
            @(negedge i_clk_sys);
        end
        `CHK(n, 5)
        // long quiet spell so the run length checks in the bank see settled phases
        repeat (1100) @(negedge i_clk_sys);
        wr(acp_pkg::ADDR_SYN, 26'h2100d60);
        `CHK(ratdiv, 1'b0)
        `CHK(fmode, 1'b0)
        n = 0;
        repeat (20) begin
            @(negedge i_clk_sys);
            n += (dith !== 1'b0);
        end
        `CHK(n, 0)
    endtask : t_dither

    // reset in mid-run acts at once and restores the reset values
    task automatic t_mid_reset();
        @(negedge i_clk_sys);
        i_rst = 1'b1;
        #1;
        `CHK(intr, acp_pkg::RST_SYN[7:0])
        repeat (3) @(negedge i_clk_sys);
        i_rst = 1'b0;
        chk_all(acp_pkg::RST_FRAC, acp_pkg::RST_SYN, acp_pkg::RST_MISC);
    endtask : t_mid_reset

    // main sequence
    initial begin
        repeat (16) @(negedge i_clk_sys);
        i_rst = 1'b0;
        t_reset_values();
        t_write_read();
        t_pump_codes();
        t_refused();
        t_dither();
        t_mid_reset();
        close_out();
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge i_clk_sys);
        errors++;
        close_out();
    end
endmodule : adc_clock_pll_config_regs_tb
